// >>> verilog/codec_bias_pkg.sv
// Constants shared by the codec bias and reset register bank.
// Assumes a plain register port with byte offsets as printed.
package codec_bias_pkg;

  // ***********************************************************
  // Bus geometry
  // ***********************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ***********************************************************
  // Register offsets
  // ***********************************************************
  localparam logic [7:0] OFS_SOFT_RESET_AND_IDENT = 8'h00;
  localparam logic [7:0] OFS_BIAS_CONTROL         = 8'h04;
  localparam logic [7:0] OFS_MIDRAIL_REF_CONTROL  = 8'h05;
  localparam logic [7:0] OFS_MIC_DETECT_CONTROL   = 8'h06;
  localparam logic [7:0] OFS_MIC_VOLTAGE_SELECT   = 8'h07;
  localparam logic [7:0] OFS_ADC_OVERSAMPLING     = 8'h0a;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int unsigned BIAS_GEN_ON_BIT      = 0;
  localparam int unsigned MASTER_BIAS_LSB      = 2;
  localparam int unsigned REF_BUFFER_ON_BIT    = 0;
  localparam int unsigned REF_DIVIDER_LSB      = 1;
  localparam int unsigned REF_UNUSED_PINS_BIT  = 6;
  localparam int unsigned MIC_SUPPLY_ON_BIT    = 0;
  localparam int unsigned MIC_DETECT_ON_BIT    = 1;
  localparam int unsigned MIC_SHORT_THR_LSB    = 2;
  localparam int unsigned MIC_CURRENT_THR_LSB  = 4;
  localparam int unsigned MIC_VOLTAGE_SEL_LSB  = 0;
  localparam int unsigned HIGH_OVERSAMPLE_BIT  = 0;

  // ***********************************************************
  // Writable bit masks, per register
  // ***********************************************************
  localparam logic [15:0] MASK_BIAS_CONTROL  = 16'h000d;
  localparam logic [15:0] MASK_MIDRAIL_REF   = 16'h0047;
  localparam logic [15:0] MASK_MIC_DETECT    = 16'h007f;
  localparam logic [15:0] MASK_MIC_VOLTAGE   = 16'h0007;
  localparam logic [15:0] MASK_ADC_OVERSAMP  = 16'h0001;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [15:0] RST_BIAS_CONTROL  = 16'h0008;
  localparam logic [15:0] RST_MIDRAIL_REF   = 16'h0000;
  localparam logic [15:0] RST_MIC_DETECT    = 16'h0000;
  localparam logic [15:0] RST_MIC_VOLTAGE   = 16'h0000;
  localparam logic [15:0] RST_ADC_OVERSAMP  = 16'h0001;

  // ***********************************************************
  // Field encodings and decoded figures
  // ***********************************************************
  localparam logic [1:0]  MASTER_BIAS_LOW_POWER = 2'h0;
  localparam logic [1:0]  MASTER_BIAS_HIGH_PERF = 2'h2;
  localparam logic [1:0]  REF_DIVIDER_OFF       = 2'h0;
  localparam logic [10:0] MIC_CURRENT_BASE_UA   = 11'h046;
  localparam logic [10:0] MIC_CURRENT_STEP_UA   = 11'h0be;
  localparam logic [10:0] MIC_SHORT_BASE_UA     = 11'h208;
  localparam logic [10:0] MIC_SHORT_STEP_UA     = 11'h168;
  localparam logic [2:0]  MIC_VOLTAGE_TOP_CODE  = 3'h4;
  localparam logic [7:0]  OSR_HIGH_PERF         = 8'h80;
  localparam logic [7:0]  OSR_LOW_POWER         = 8'h40;

endpackage

// >>> verilog/ctrl_field.sv
// One control register with a reset value and a writable-bit mask.
// Assumes load and soft clear never arrive in the same cycle.
`timescale 1ns/1ps
module ctrl_field #(
  parameter int unsigned       W         = 16,
  parameter logic [W-1:0]      RESET_VAL = '0,
  parameter logic [W-1:0]      MASK      = '1
) (
  // Clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  // Control
  input  wire logic            soft_clear_i,
  input  wire logic            load_i,
  input  wire logic [W-1:0]    data_i,
  // Stored value
  output logic      [W-1:0]    value_o
);

  // Unassigned bits are masked off so they always read as zero.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      value_o <= RESET_VAL & MASK;
    end else if (soft_clear_i) begin
      value_o <= RESET_VAL & MASK;
    end else if (load_i) begin
      value_o <= data_i & MASK;
    end
  end

endmodule

// >>> verilog/read_return.sv
// Read data register: holds the selected word for one cycle after a read.
// Assumes the caller presents the selected word beside the read strobe.
`timescale 1ns/1ps
module read_return #(
  parameter int unsigned    W = 16
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // Request side
  input  wire logic         rd_i,
  input  wire logic [W-1:0] word_i,
  // Answer side
  output logic      [W-1:0] rd_data_o
);

  // Outside the answer cycle the port reads zero, never stale data.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_i) begin
      rd_data_o <= word_i;
    end else begin
      rd_data_o <= '0;
    end
  end

endmodule

// >>> verilog/codec_bias_regs.sv
// Codec bias, reference, microphone supply and converter control registers.
// Assumes a single-master register port on ref_clk_i; outputs feed
// analogue enables and selects outside this block.
//
// How it works
// R1 - Any write to offset zero restores defaults
// R2 - Offset zero reads the fixed identification code
// R3 - Master bias select resets to high performance
// R4 - Host changes bias select only in sequences
// R5 - Bias control bit 0 enables bias generator
// R6 - Reference bit 6 unused pins, bit 0 buffer
// R7 - Reference divider field resets to off
// R8 - Mic current threshold field, eight even steps
// R9 - Mic short threshold field, four ascending steps
// R10 - Mic bit 1 detect, bit 0 supply
// R11 - Mic voltage codes four and up saturate
// R12 - Oversampling bit resets high, 128 or 64
// R13 - Unassigned bits read zero, writes ignored
// R14 - Sixteen-bit registers updated whole in one step
`timescale 1ns/1ps
module codec_bias_regs #(
  // Arbitrary identification value, not tied to any real part.
  parameter logic [15:0] IDENT_CODE = 16'h5a3c
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rd_data_o,
  // Master bias
  output logic             bias_generator_on_o,
  output logic      [1:0]  master_bias_select_o,
  output logic             master_bias_reserved_o,
  // Mid-rail reference
  output logic             reference_to_unused_pins_on_o,
  output logic      [1:0]  reference_divider_select_o,
  output logic             reference_buffer_on_o,
  output logic             midrail_reference_on_o,
  // Microphone supply
  output logic      [2:0]  mic_current_threshold_o,
  output logic      [10:0] mic_current_threshold_ua_o,
  output logic      [1:0]  mic_short_threshold_o,
  output logic      [10:0] mic_short_threshold_ua_o,
  output logic             mic_detect_on_o,
  output logic             mic_supply_on_o,
  output logic      [2:0]  mic_supply_voltage_select_o,
  output logic      [2:0]  mic_supply_level_o,
  // Converter
  output logic             converter_high_oversample_o,
  output logic      [7:0]  converter_osr_o,
  // Soft reset event
  output logic             soft_reset_pulse_o
);

  // ***********************************************************
  // Helper functions
  // ***********************************************************

  // Exact offset match; the port has no byte lanes or aliases.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Threshold in microamps: base plus code times step.
  function automatic logic [10:0] thr_ua(input logic [2:0]  code,
                                         input logic [10:0] base,
                                         input logic [10:0] step);
    logic [21:0] prod;
    prod   = 22'(code) * 22'(step);
    thr_ua = base + prod[10:0];
  endfunction

  // Voltage ratio index: codes above the top one map onto it.
  function automatic logic [2:0] level_of(input logic [2:0] code);
    if (code >= codec_bias_pkg::MIC_VOLTAGE_TOP_CODE) begin
      level_of = codec_bias_pkg::MIC_VOLTAGE_TOP_CODE;
    end else begin
      level_of = code;
    end
  endfunction

  // Only low power and high performance are legal bias codes.
  function automatic logic bias_reserved(input logic [1:0] code);
    bias_reserved = (code != codec_bias_pkg::MASTER_BIAS_LOW_POWER) &&
                    (code != codec_bias_pkg::MASTER_BIAS_HIGH_PERF);
  endfunction

  function automatic logic [7:0] osr_of(input logic high);
    osr_of = high ? codec_bias_pkg::OSR_HIGH_PERF
                  : codec_bias_pkg::OSR_LOW_POWER;
  endfunction

  // ***********************************************************
  // Address decode
  // ***********************************************************
  logic        soft_reset_wr;
  logic        bias_wr;
  logic        ref_wr;
  logic        mic_det_wr;
  logic        mic_volt_wr;
  logic        adc_wr;

  // Any data written to offset zero only triggers the restore.
  assign soft_reset_wr = wr_i &&
    hit(addr_i, codec_bias_pkg::OFS_SOFT_RESET_AND_IDENT); // see R1
  assign bias_wr       = wr_i &&
    hit(addr_i, codec_bias_pkg::OFS_BIAS_CONTROL);
  assign ref_wr        = wr_i &&
    hit(addr_i, codec_bias_pkg::OFS_MIDRAIL_REF_CONTROL);
  assign mic_det_wr    = wr_i &&
    hit(addr_i, codec_bias_pkg::OFS_MIC_DETECT_CONTROL);
  assign mic_volt_wr   = wr_i &&
    hit(addr_i, codec_bias_pkg::OFS_MIC_VOLTAGE_SELECT);
  assign adc_wr        = wr_i &&
    hit(addr_i, codec_bias_pkg::OFS_ADC_OVERSAMPLING);

  // ***********************************************************
  // Register storage
  // ***********************************************************
  logic [15:0] bias_q;
  logic [15:0] ref_q;
  logic [15:0] mic_det_q;
  logic [15:0] mic_volt_q;
  logic [15:0] adc_q;

  // Each register loads its whole word on one edge. // see R14
  // Masks drop unassigned bits on write and read. // see R13
  ctrl_field #(
    .W         (16),
    .RESET_VAL (codec_bias_pkg::RST_BIAS_CONTROL), // see R3
    .MASK      (codec_bias_pkg::MASK_BIAS_CONTROL)
  ) u_bias (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .soft_clear_i (soft_reset_wr), // see R1
    .load_i       (bias_wr),
    .data_i       (wr_data_i),
    .value_o      (bias_q)
  );

  ctrl_field #(
    .W         (16),
    .RESET_VAL (codec_bias_pkg::RST_MIDRAIL_REF), // see R7
    .MASK      (codec_bias_pkg::MASK_MIDRAIL_REF)
  ) u_ref (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .soft_clear_i (soft_reset_wr), // see R1
    .load_i       (ref_wr),
    .data_i       (wr_data_i),
    .value_o      (ref_q)
  );

  ctrl_field #(
    .W         (16),
    .RESET_VAL (codec_bias_pkg::RST_MIC_DETECT), // see R8
    .MASK      (codec_bias_pkg::MASK_MIC_DETECT)
  ) u_mic_det (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .soft_clear_i (soft_reset_wr), // see R1
    .load_i       (mic_det_wr),
    .data_i       (wr_data_i),
    .value_o      (mic_det_q)
  );

  ctrl_field #(
    .W         (16),
    .RESET_VAL (codec_bias_pkg::RST_MIC_VOLTAGE), // see R11
    .MASK      (codec_bias_pkg::MASK_MIC_VOLTAGE)
  ) u_mic_volt (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .soft_clear_i (soft_reset_wr), // see R1
    .load_i       (mic_volt_wr),
    .data_i       (wr_data_i),
    .value_o      (mic_volt_q)
  );

  ctrl_field #(
    .W         (16),
    .RESET_VAL (codec_bias_pkg::RST_ADC_OVERSAMP), // see R12
    .MASK      (codec_bias_pkg::MASK_ADC_OVERSAMP)
  ) u_adc (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .soft_clear_i (soft_reset_wr), // see R1
    .load_i       (adc_wr),
    .data_i       (wr_data_i),
    .value_o      (adc_q)
  );

  // ***********************************************************
  // Read path
  // ***********************************************************
  logic [15:0] rd_word;

  always_comb begin
    case (addr_i)
      codec_bias_pkg::OFS_SOFT_RESET_AND_IDENT: begin
        rd_word = IDENT_CODE; // see R2
      end
      codec_bias_pkg::OFS_BIAS_CONTROL: begin
        rd_word = bias_q;
      end
      codec_bias_pkg::OFS_MIDRAIL_REF_CONTROL: begin
        rd_word = ref_q;
      end
      codec_bias_pkg::OFS_MIC_DETECT_CONTROL: begin
        rd_word = mic_det_q;
      end
      codec_bias_pkg::OFS_MIC_VOLTAGE_SELECT: begin
        rd_word = mic_volt_q;
      end
      codec_bias_pkg::OFS_ADC_OVERSAMPLING: begin
        rd_word = adc_q;
      end
      default: begin
        rd_word = 16'h0000; // see R13
      end
    endcase
  end

  read_return #(
    .W (16)
  ) u_read (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .rd_i      (rd_i),
    .word_i    (rd_word),
    .rd_data_o (rd_data_o)
  );

  // ***********************************************************
  // Field outputs
  // ***********************************************************
  // Fields are taken straight from the stored words, so every output
  // changes on the same edge as the register that holds it.
  localparam int unsigned MB = codec_bias_pkg::MASTER_BIAS_LSB;
  localparam int unsigned RD = codec_bias_pkg::REF_DIVIDER_LSB;
  localparam int unsigned CT = codec_bias_pkg::MIC_CURRENT_THR_LSB;
  localparam int unsigned ST = codec_bias_pkg::MIC_SHORT_THR_LSB;
  localparam int unsigned VS = codec_bias_pkg::MIC_VOLTAGE_SEL_LSB;

  assign bias_generator_on_o =
    bias_q[codec_bias_pkg::BIAS_GEN_ON_BIT]; // see R5
  // The host keeps this field steady outside the low-power entry and
  // exit sequences; no interlock is built here. // see R4
  assign master_bias_select_o = bias_q[MB+1:MB]; // see R3

  assign reference_to_unused_pins_on_o =
    ref_q[codec_bias_pkg::REF_UNUSED_PINS_BIT]; // see R6
  assign reference_buffer_on_o =
    ref_q[codec_bias_pkg::REF_BUFFER_ON_BIT]; // see R6
  assign reference_divider_select_o = ref_q[RD+1:RD]; // see R7

  assign mic_current_threshold_o = mic_det_q[CT+2:CT]; // see R8
  assign mic_short_threshold_o   = mic_det_q[ST+1:ST]; // see R9
  assign mic_detect_on_o =
    mic_det_q[codec_bias_pkg::MIC_DETECT_ON_BIT]; // see R10
  assign mic_supply_on_o =
    mic_det_q[codec_bias_pkg::MIC_SUPPLY_ON_BIT]; // see R10

  assign mic_supply_voltage_select_o = mic_volt_q[VS+2:VS]; // see R11

  assign converter_high_oversample_o =
    adc_q[codec_bias_pkg::HIGH_OVERSAMPLE_BIT]; // see R12

  // ***********************************************************
  // Decoded status
  // ***********************************************************
  // Decoded figures are kept in their own flops and loaded from the
  // write data, so they never lag the raw fields by a cycle.
  logic [1:0] wr_bias_sel;
  logic [1:0] wr_ref_div;
  logic [2:0] wr_cur_thr;
  logic [2:0] wr_short_thr;
  logic [2:0] wr_volt_sel;
  logic       wr_high_osr;

  assign wr_bias_sel  = wr_data_i[MB+1:MB];
  assign wr_ref_div   = wr_data_i[RD+1:RD];
  assign wr_cur_thr   = wr_data_i[CT+2:CT];
  assign wr_short_thr = {1'b0, wr_data_i[ST+1:ST]};
  assign wr_volt_sel  = wr_data_i[VS+2:VS];
  assign wr_high_osr  = wr_data_i[codec_bias_pkg::HIGH_OVERSAMPLE_BIT];

  // Reset figures derived from the stored defaults.
  localparam logic [15:0] RB = codec_bias_pkg::RST_BIAS_CONTROL;
  localparam logic [15:0] RR = codec_bias_pkg::RST_MIDRAIL_REF;
  localparam logic [15:0] RM = codec_bias_pkg::RST_MIC_DETECT;
  localparam logic [15:0] RV = codec_bias_pkg::RST_MIC_VOLTAGE;
  localparam logic [15:0] RA = codec_bias_pkg::RST_ADC_OVERSAMP;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset_wr) begin
      master_bias_reserved_o <= bias_reserved(RB[MB+1:MB]); // see R3
    end else if (bias_wr) begin
      master_bias_reserved_o <= bias_reserved(wr_bias_sel);
    end
  end

  // A divider code of zero means the reference is switched off.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset_wr) begin
      midrail_reference_on_o <=
        (RR[RD+1:RD] != codec_bias_pkg::REF_DIVIDER_OFF); // see R7
    end else if (ref_wr) begin
      midrail_reference_on_o <=
        (wr_ref_div != codec_bias_pkg::REF_DIVIDER_OFF);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset_wr) begin
      mic_current_threshold_ua_o <= thr_ua(RM[CT+2:CT],
        codec_bias_pkg::MIC_CURRENT_BASE_UA,
        codec_bias_pkg::MIC_CURRENT_STEP_UA);
      mic_short_threshold_ua_o   <= thr_ua({1'b0, RM[ST+1:ST]},
        codec_bias_pkg::MIC_SHORT_BASE_UA,
        codec_bias_pkg::MIC_SHORT_STEP_UA);
    end else if (mic_det_wr) begin
      mic_current_threshold_ua_o <= thr_ua(wr_cur_thr,
        codec_bias_pkg::MIC_CURRENT_BASE_UA,
        codec_bias_pkg::MIC_CURRENT_STEP_UA); // see R8
      mic_short_threshold_ua_o   <= thr_ua(wr_short_thr,
        codec_bias_pkg::MIC_SHORT_BASE_UA,
        codec_bias_pkg::MIC_SHORT_STEP_UA); // see R9
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset_wr) begin
      mic_supply_level_o <= level_of(RV[VS+2:VS]);
    end else if (mic_volt_wr) begin
      mic_supply_level_o <= level_of(wr_volt_sel); // see R11
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset_wr) begin
      converter_osr_o <= osr_of(RA[codec_bias_pkg::HIGH_OVERSAMPLE_BIT]);
    end else if (adc_wr) begin
      converter_osr_o <= osr_of(wr_high_osr); // see R12
    end
  end

  // ***********************************************************
  // Soft reset event
  // ***********************************************************
  // Lets the rest of the codec restore its own defaults in step.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      soft_reset_pulse_o <= 1'b0;
    end else begin
      soft_reset_pulse_o <= soft_reset_wr; // see R1
    end
  end

endmodule

// >>> verif/codec_bias_regs_sva.sv
// Concurrent checks for the codec bias register bank, on its ports only.
// Assumes one clock, a synchronous active-low reset and one-cycle reads.
`timescale 1ns/1ps
module codec_bias_regs_sva #(
  parameter logic [15:0] IDENT_CODE = 16'h5a3c
) (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  // Register port
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rd_data_o,
  // Field outputs
  input wire logic        bias_generator_on_o,
  input wire logic [1:0]  master_bias_select_o,
  input wire logic        master_bias_reserved_o,
  input wire logic        reference_to_unused_pins_on_o,
  input wire logic [1:0]  reference_divider_select_o,
  input wire logic        reference_buffer_on_o,
  input wire logic        midrail_reference_on_o,
  input wire logic [2:0]  mic_current_threshold_o,
  input wire logic [10:0] mic_current_threshold_ua_o,
  input wire logic [1:0]  mic_short_threshold_o,
  input wire logic [10:0] mic_short_threshold_ua_o,
  input wire logic        mic_detect_on_o,
  input wire logic        mic_supply_on_o,
  input wire logic [2:0]  mic_supply_voltage_select_o,
  input wire logic [2:0]  mic_supply_level_o,
  input wire logic        converter_high_oversample_o,
  input wire logic [7:0]  converter_osr_o,
  input wire logic        soft_reset_pulse_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Write data of the last cycle.
  logic [15:0] wd_q;
  always_ff @(posedge ref_clk_i) begin
    wd_q <= wr_data_i;
  end

  // *********************************************************
  // Soft reset steps, read returns and field checks
  // *********************************************************
  sequence s_zero_write;
    wr_i && addr_i == 8'h00 ##1 !(wr_i && addr_i == 8'h00);
  endsequence
  sequence s_defaults;
    soft_reset_pulse_o && master_bias_select_o == 2'h2 &&
    !bias_generator_on_o && reference_divider_select_o == 2'h0 &&
    !reference_buffer_on_o && !reference_to_unused_pins_on_o &&
    mic_current_threshold_o == 3'h0 && mic_short_threshold_o == 2'h0 &&
    !mic_detect_on_o && !mic_supply_on_o &&
    mic_supply_voltage_select_o == 3'h0 && converter_high_oversample_o;
  endsequence

  property p_soft_reset;
    s_zero_write |-> s_defaults ##1 !soft_reset_pulse_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("defaults not restored");

  property p_ident_read;
    rd_i && addr_i == 8'h00 |=> rd_data_o == IDENT_CODE;
  endproperty
  a_ident_read: assert property (p_ident_read)
    else $error("identity read wrong");

  property p_bias_read;
    rd_i && addr_i == 8'h04 |=> rd_data_o ==
      {12'h000, master_bias_select_o, 1'b0, bias_generator_on_o};
  endproperty
  a_bias_read: assert property (p_bias_read)
    else $error("bias read wrong");

  property p_read_idle;
    !rd_i |=> rd_data_o == 16'h0000;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero");

  property p_ref_write;
    wr_i && addr_i == 8'h05 |=> {reference_to_unused_pins_on_o,
      reference_divider_select_o, reference_buffer_on_o} ==
      {wd_q[6], wd_q[2:1], wd_q[0]} &&
      midrail_reference_on_o == (wd_q[2:1] != 2'h0);
  endproperty
  a_ref_write: assert property (p_ref_write)
    else $error("reference write wrong");

  property p_mic_write;
    wr_i && addr_i == 8'h06 |=> {mic_current_threshold_o,
      mic_short_threshold_o, mic_detect_on_o, mic_supply_on_o} == wd_q[6:0];
  endproperty
  a_mic_write: assert property (p_mic_write)
    else $error("mic write wrong");

  property p_current_ua;
    mic_current_threshold_ua_o ==
      11'h046 + 11'h0be * {8'h00, mic_current_threshold_o};
  endproperty
  a_current_ua: assert property (p_current_ua)
    else $error("current figure wrong");

  property p_short_ua;
    mic_short_threshold_ua_o ==
      11'h208 + 11'h168 * {9'h000, mic_short_threshold_o};
  endproperty
  a_short_ua: assert property (p_short_ua)
    else $error("short figure wrong");

  property p_supply_level;
    mic_supply_level_o == (mic_supply_voltage_select_o[2] ? 3'h4 :
      mic_supply_voltage_select_o);
  endproperty
  a_supply_level: assert property (p_supply_level)
    else $error("supply level wrong");

  property p_osr;
    wr_i && addr_i == 8'h0a |=> converter_high_oversample_o == wd_q[0] &&
      converter_osr_o == (wd_q[0] ? 8'h80 : 8'h40);
  endproperty
  a_osr: assert property (p_osr)
    else $error("oversampling wrong");

  property p_pulse_cause;
    $rose(soft_reset_pulse_o) |-> $past(wr_i) && $past(addr_i) == 8'h00;
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("stray soft reset pulse");

  property p_reserved_flag;
    master_bias_reserved_o == master_bias_select_o[0];
  endproperty
  a_reserved_flag: assert property (p_reserved_flag)
    else $error("reserved bias flag wrong");
endmodule

bind codec_bias_regs codec_bias_regs_sva #(.IDENT_CODE(IDENT_CODE)) u_sva (.*);

// >>> verif/codec_bias_regs_test.sv
// Self-checking bench for the codec bias register bank.
// Assumes the bound checker; drives the register port straight.
`timescale 1ns/1ps
module codec_bias_regs_test;
  // Arbitrary identification value, not tied to any real part.
  localparam logic [15:0] ID = 16'h9c61;
  logic        ref_clk_i, rst_n_i, wr_i, rd_i, pend;
  logic [7:0]  addr_i;
  logic [15:0] wr_data_i, rd_data_o, pend_exp, c;
  logic        gen_on, resv, unused_on, buf_on, ref_on, det_on, sup_on;
  logic        hi_osr, pulse;
  logic [1:0]  bias_sel, div_sel, short_thr;
  logic [2:0]  cur_thr, volt_sel, level;
  logic [10:0] cur_ua, short_ua;
  logic [7:0]  osr;
  int          fail_count, comparisons;
  logic [7:0]  ofs  [5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a};
  logic [15:0] rstv [5] = '{16'h0008, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
  logic [15:0] mask [5] = '{16'h000d, 16'h0047, 16'h007f, 16'h0007, 16'h0001};

  codec_bias_regs #(.IDENT_CODE(ID)) DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .bias_generator_on_o(gen_on), .master_bias_select_o(bias_sel),
    .master_bias_reserved_o(resv), .reference_to_unused_pins_on_o(unused_on),
    .reference_divider_select_o(div_sel), .reference_buffer_on_o(buf_on),
    .midrail_reference_on_o(ref_on), .mic_current_threshold_o(cur_thr),
    .mic_current_threshold_ua_o(cur_ua), .mic_short_threshold_o(short_thr),
    .mic_short_threshold_ua_o(short_ua), .mic_detect_on_o(det_on),
    .mic_supply_on_o(sup_on), .mic_supply_voltage_select_o(volt_sel),
    .mic_supply_level_o(level), .converter_high_oversample_o(hi_osr),
    .converter_osr_o(osr), .soft_reset_pulse_o(pulse)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus cycle; judges the read data of the cycle before.
  task automatic cycle(input logic w, input logic r, input logic [7:0] a,
                       input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i      <= w;
    rd_i      <= r;
    addr_i    <= a;
    wr_data_i <= d;
    #1;
    chk("read data", pend ? pend_exp : 16'h0000, rd_data_o);
    pend = r;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cycle(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    cycle(1'b0, 1'b1, a, 16'h0000);
    pend_exp = exp;
  endtask

  task automatic idle();
    cycle(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fail_count++;
    print_verdict();
  end

  initial begin
    rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00;
    wr_data_i = 16'h0000; pend = 1'b0; pend_exp = 16'h0000;
    fail_count = 0; comparisons = 0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ofs[i], rstv[i]);
    rd(8'h00, ID);
    rd(8'h01, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 16'hffff);
      rd(ofs[i], mask[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 16'h0000);
      rd(ofs[i], 16'h0000);
    end
    idle();
    chk("osr low", 16'h0040, {8'h00, osr});
    for (c = 16'h0000; c < 16'h0008; c++) begin
      wr(8'h07, c);
      wr(8'h06, {9'h000, c[2:0], c[1:0], 2'h3});
      wr(8'h05, {9'h000, c[0], 3'h0, c[1:0], c[2]});
      wr(8'h04, {12'h000, c[1:0], 2'h0});
      idle();
      chk("level", c[2] ? 16'h0004 : c, {13'h0000, level});
      chk("cur ua", 16'h0046 + 16'h00be * c, {5'h00, cur_ua});
      chk("short ua", 16'h0208 + 16'h0168 * c[1:0],
          {5'h00, short_ua});
      chk("det sup", 16'h0003, {14'h0000, det_on, sup_on});
      chk("ref", {12'h000, c[0], c[1:0], c[2]},
          {12'h000, unused_on, div_sel, buf_on});
      chk("ref on", {15'h0000, c[1:0] != 2'h0}, {15'h0000, ref_on});
      chk("resv", {15'h0000, c[0]}, {15'h0000, resv});
      chk("fields", {6'h00, c[1:0], c[2:0], c[1:0], c[2:0]},
          {6'h00, bias_sel, cur_thr, short_thr, volt_sel});
    end
    wr(8'h08, 16'hffff);
    wr(8'h01, 16'hffff);
    rd(8'h08, 16'h0000);
    rd(8'h04, 16'h000c);
    rd(8'h06, 16'h007f);
    wr(8'h00, 16'h1234);
    rd(8'h05, 16'h0000);
    chk("pulse", 16'h0001, {15'h0000, pulse});
    for (int i = 0; i < 5; i++) rd(ofs[i], rstv[i]);
    chk("pulse gone", 16'h0000, {15'h0000, pulse});
    rd(8'h00, ID);
    wr(8'h0a, 16'h0000);
    idle();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    pend = 1'b0;
    rd(8'h0a, 16'h0001);
    idle();
    chk("osr high", 16'h0080, {8'h00, osr});
    print_verdict();
  end
endmodule
